// ### rtl/adss_consts.vh
`ifndef ADSS_CONSTS_VH
`define ADSS_CONSTS_VH

// APB register byte addresses.
`define ADSS_ADDR_CTRL 12'h000
`define ADSS_ADDR_PLL 12'h004
`define ADSS_ADDR_LINK 12'h008
`define ADSS_ADDR_CAL 12'h00c
`define ADSS_ADDR_REFOUT 12'h010
`define ADSS_ADDR_STATUS 12'h014

// Control register bits.
`define ADSS_CTRL_SOFT_RESET 0
`define ADSS_CTRL_LINK_EN 1
`define ADSS_CTRL_CAL_EN 2
`define ADSS_CTRL_OVER_RANGE_ENABLE 3
`define ADSS_CTRL_SW_TRIG 4
`define ADSS_CTRL_PIN_TRIG_EN 5
`define ADSS_CTRL_STAT_SEL 6
`define ADSS_CTRL_RESET 32'h0000_0016

// PLL register fields.
`define ADSS_PLL_RESET_BIT 0
`define ADSS_PLL_CAL_EN_BIT 1
`define ADSS_PLL_RESET_VAL 32'h0000_0001
`define ADSS_FIELD_A_LSB 8
`define ADSS_FIELD_A_REQ 8'h4a

// Link register fields.
`define ADSS_LINK_MODE_MSB 4
`define ADSS_LINK_MODE_LSB 0
`define ADSS_LINK_KM1_MSB 15
`define ADSS_LINK_KM1_LSB 8
`define ADSS_LINK_SYNC_SEL 16
`define ADSS_MODE_64B66B 5'h08

// Calibration option bits.
`define ADSS_CAL_BG_MODE 0
`define ADSS_CAL_OFFSET 1

// Status register bits.
`define ADSS_ST_INIT_DONE 0
`define ADSS_ST_VCO_DONE 1
`define ADSS_ST_PLL_LOCK 2
`define ADSS_ST_FOREGROUND_CAL_DONE_BIT 3
`define ADSS_ST_LINK_RUN 4
`define ADSS_ST_CAL_RUN 5
`define ADSS_ST_SYNC_REQ 6
`define ADSS_ST_REF_SE 7
`define ADSS_ST_STRAP_BAD 8

// Timing counts in clock cycles at 100 MHz, sized to the timer width.
`define ADSS_INIT_CYC 16'h00c8
`define ADSS_VCO_CAL_CYC 16'h01f4
`define ADSS_LOCK_CYC 16'h0064
`define ADSS_FG_CAL_CYC 16'h012c

`endif

// ### rtl/adss_seq.v
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "adss_consts.vh"

// How it works
// - Soft reset runs initialization; init-done bit rises when it ends.
// - Clearing PLL reset starts PLL lock, and VCO calibration if the PLL calibration-enable bit is set, when the strap enables the PLL.
// - Link enable at 0 drops the link-run and sync-request outputs.
// - Calibration enable at 0 halts the calibration state machine.
// - Device reports VCO calibration done and PLL locked status bits.
// - Software trigger written 0 then 1 starts foreground calibration.
// - With pin trigger enabled, trigger pin low then high starts calibration.
// - Finished calibration sets done bit and, with status select at 0, drives status pin high.
// - 8B/10B modes act on SYNC; 64B/66B modes ignore it.
// - Link mode 8 is 64B/66B: no SYNC, no multiframe length.
module adss_seq (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Straps and pins
    input wire pll_enable_strap_i,
    input wire ref_select_strap_i,
    input wire cal_trigger_pin_i,
    input wire single_ended_sync_input_i,
    input wire timestamp_diff_input_i,
    // Pin outputs
    output reg cal_status_pin_o,
    output reg link_run_o,
    output reg link_sync_req_o,
    output reg transceiver_ref_out_en_o
);
    // ==========================================================
    // Sequencer states
    localparam [3:0] ST_INIT = 4'b0001;
    localparam [3:0] ST_IDLE = 4'b0010;
    localparam [3:0] ST_CAL = 4'b0100;
    localparam [3:0] ST_HALT = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [31:0] ctrl;
    reg [31:0] pll;
    reg [31:0] link;
    reg [31:0] cal;
    reg [31:0] refout;
    reg init_done;
    reg vco_done;
    reg pll_lock;
    reg foreground_cal_done_bit;
    reg pll_en;
    reg strap_taken;
    reg trig_pin_q;
    reg soft_trig_q;
    reg pll_reset_q;
    reg ref_se;
    reg [31:0] status_word;
    wire init_fin;
    wire vco_fin;
    wire lock_fin;
    wire cal_fin;
    wire vco_busy;
    wire lock_busy;
    wire cal_busy;

    // ==========================================================
    // Decoded controls
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    wire rd_addr_ok = (paddr_i == `ADSS_ADDR_CTRL) || (paddr_i == `ADSS_ADDR_PLL) ||
                      (paddr_i == `ADSS_ADDR_LINK) || (paddr_i == `ADSS_ADDR_CAL) ||
                      (paddr_i == `ADSS_ADDR_REFOUT) || (paddr_i == `ADSS_ADDR_STATUS);
    wire soft_reset_go = wr && (paddr_i == `ADSS_ADDR_CTRL) &&
                         pwdata_i[`ADSS_CTRL_SOFT_RESET];
    wire cal_en = ctrl[`ADSS_CTRL_CAL_EN];
    wire pll_rst_bit = pll[`ADSS_PLL_RESET_BIT];
    wire mode_is_64 = (link[`ADSS_LINK_MODE_MSB:`ADSS_LINK_MODE_LSB] == `ADSS_MODE_64B66B);
    wire sync_src = link[`ADSS_LINK_SYNC_SEL] ? timestamp_diff_input_i :
                    single_ended_sync_input_i;
    wire sw_trig = ~soft_trig_q & ctrl[`ADSS_CTRL_SW_TRIG];
    wire pin_trig = ctrl[`ADSS_CTRL_PIN_TRIG_EN] & ~trig_pin_q & cal_trigger_pin_i;
    wire cal_start = (state == ST_IDLE) && cal_en && (sw_trig || pin_trig);
    // Calibration and lock start on the falling edge of the PLL reset bit.
    wire vco_start = pll_en && pll_reset_q && !pll_rst_bit &&
                     pll[`ADSS_PLL_CAL_EN_BIT];
    wire lock_start = pll_en && pll_reset_q && !pll_rst_bit;

    // ==========================================================
    // Timers
    // Initialization runs once after reset release and again on every soft reset.
    adss_timer #(.COUNT(`ADSS_INIT_CYC)) u_init (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(soft_reset_go || !strap_taken),
        .abort_i(1'b0),
        .busy_o(),
        .done_o(init_fin)
    );

    // Each engine timer is cleared by the same condition that halts the engine.
    adss_timer #(.COUNT(`ADSS_VCO_CAL_CYC)) u_vco (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(vco_start),
        .abort_i(pll_rst_bit),
        .busy_o(vco_busy),
        .done_o(vco_fin)
    );

    adss_timer #(.COUNT(`ADSS_LOCK_CYC)) u_lock (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(lock_start),
        .abort_i(pll_rst_bit),
        .busy_o(lock_busy),
        .done_o(lock_fin)
    );

    adss_timer #(.COUNT(`ADSS_FG_CAL_CYC)) u_cal (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(cal_start),
        .abort_i(!cal_en),
        .busy_o(cal_busy),
        .done_o(cal_fin)
    );

    // ==========================================================
    // Calibration state machine
    always @* begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (init_fin) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!cal_en) begin
                    next_state = ST_HALT;
                end else if (cal_start) begin
                    next_state = ST_CAL;
                end
            end
            ST_CAL: begin
                if (!cal_en) begin
                    next_state = ST_HALT;
                end else if (cal_fin) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (cal_en) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase
        if (soft_reset_go) begin
            next_state = ST_INIT;
        end
    end

    // ==========================================================
    // Registers and status
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_INIT;
            ctrl <= `ADSS_CTRL_RESET;
            pll <= `ADSS_PLL_RESET_VAL;
            link <= 32'h0000_0000;
            cal <= 32'h0000_0000;
            refout <= 32'h0000_0000;
            init_done <= 1'b0;
            vco_done <= 1'b0;
            pll_lock <= 1'b0;
            foreground_cal_done_bit <= 1'b0;
            pll_en <= 1'b0;
            ref_se <= 1'b0;
            strap_taken <= 1'b0;
            // Edge detectors start at the idle level, so release gives no false edge.
            trig_pin_q <= 1'b1;
            soft_trig_q <= 1'b1;
            pll_reset_q <= 1'b1;
        end else begin
            state <= next_state;
            trig_pin_q <= cal_trigger_pin_i;
            soft_trig_q <= ctrl[`ADSS_CTRL_SW_TRIG];
            pll_reset_q <= pll_rst_bit;
            if (!strap_taken) begin
                strap_taken <= 1'b1;
                pll_en <= pll_enable_strap_i;
                ref_se <= ref_select_strap_i;
            end
            if (soft_reset_go) begin
                init_done <= 1'b0;
            end else if (init_fin) begin
                init_done <= 1'b1;
            end
            if (pll_rst_bit || !pll_en) begin
                vco_done <= 1'b0;
                pll_lock <= 1'b0;
            end else begin
                if (vco_fin || (lock_start && !pll[`ADSS_PLL_CAL_EN_BIT])) begin
                    vco_done <= 1'b1;
                end
                if (lock_fin) begin
                    pll_lock <= 1'b1;
                end
            end
            // A halted calibration leaves the done flag as it was.
            if (cal_fin && state == ST_CAL) begin
                foreground_cal_done_bit <= 1'b1;
            end else if (cal_start) begin
                foreground_cal_done_bit <= 1'b0;
            end
            if (wr) begin
                case (paddr_i)
                    // Bit 0 is never stored: soft reset clears itself and reads back 0.
                    `ADSS_ADDR_CTRL: ctrl <= {25'h0, pwdata_i[6:1], 1'b0};
                    `ADSS_ADDR_PLL: pll <= pwdata_i;
                    `ADSS_ADDR_LINK: link <= pwdata_i;
                    `ADSS_ADDR_CAL: cal <= pwdata_i;
                    `ADSS_ADDR_REFOUT: refout <= pwdata_i;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Status word
    // Built from the named bit positions so the map lives in one place.
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`ADSS_ST_INIT_DONE] = init_done;
        status_word[`ADSS_ST_VCO_DONE] = vco_done;
        status_word[`ADSS_ST_PLL_LOCK] = pll_lock;
        status_word[`ADSS_ST_FOREGROUND_CAL_DONE_BIT] = foreground_cal_done_bit;
        status_word[`ADSS_ST_LINK_RUN] = link_run_o;
        status_word[`ADSS_ST_CAL_RUN] = (state == ST_CAL);
        status_word[`ADSS_ST_SYNC_REQ] = link_sync_req_o;
        status_word[`ADSS_ST_REF_SE] = ref_se;
        status_word[`ADSS_ST_STRAP_BAD] = ref_se && !pll_en;
    end

    // ==========================================================
    // APB answer and pin outputs
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            cal_status_pin_o <= 1'b0;
            link_run_o <= 1'b0;
            link_sync_req_o <= 1'b0;
            transceiver_ref_out_en_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !rd_addr_ok;
            prdata_o <= 32'h0000_0000;
            if (psel_i && !penable_i && !pwrite_i) begin
                case (paddr_i)
                    `ADSS_ADDR_CTRL: prdata_o <= ctrl;
                    `ADSS_ADDR_PLL: prdata_o <= pll;
                    `ADSS_ADDR_LINK: prdata_o <= link;
                    `ADSS_ADDR_CAL: prdata_o <= cal;
                    `ADSS_ADDR_REFOUT: prdata_o <= refout;
                    `ADSS_ADDR_STATUS: prdata_o <= status_word;
                    default: prdata_o <= 32'h0000_0000;
                endcase
            end
            cal_status_pin_o <= foreground_cal_done_bit && !ctrl[`ADSS_CTRL_STAT_SEL];
            link_run_o <= ctrl[`ADSS_CTRL_LINK_EN] && init_done;
            // In 64B/66B modes a receiver that keeps asserting sync has no effect.
            link_sync_req_o <= ctrl[`ADSS_CTRL_LINK_EN] && !mode_is_64 &&
                               sync_src;
            transceiver_ref_out_en_o <= refout[0];
        end
    end
endmodule

// ### rtl/adss_timer.v
`timescale 1ns/1ps
`include "adss_consts.vh"

// Down-counter: a start pulse loads the count, done rises when it expires.
module adss_timer #(
    parameter [15:0] COUNT = 16'h0001
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Control
    input wire start_i,
    input wire abort_i,
    // Status
    output reg busy_o,
    output reg done_o
);
    reg [15:0] remain;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                busy_o <= 1'b0;
                remain <= 16'h0000;
            end else if (start_i) begin
                busy_o <= 1'b1;
                remain <= COUNT;
            end else if (busy_o) begin
                if (remain == 16'h0001) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                remain <= remain - 16'h0001;
            end
        end
    end
endmodule

// ### sim/adss_rx_model.sv
`timescale 1ns/1ps
// ====================
// Receiver side: sync request on one chosen source, and the trigger pin.
module adss_rx_model (
    // Clock
    input wire clock_i,
    // Bench control
    input wire req_i,
    input wire sel_i,
    // Pins
    output reg single_ended_sync_input_o,
    output reg timestamp_diff_input_o,
    output reg cal_trigger_pin_o
);
    initial begin
        single_ended_sync_input_o = 1'b0;
        timestamp_diff_input_o = 1'b0;
        cal_trigger_pin_o = 1'b1;
    end
    always @(posedge clock_i) begin
        single_ended_sync_input_o <= req_i && !sel_i;
        timestamp_diff_input_o <= req_i && sel_i;
    end
    task pulse_trig;
        begin
            @(posedge clock_i);
            cal_trigger_pin_o <= 1'b0;
            repeat (2) @(posedge clock_i);
            cal_trigger_pin_o <= 1'b1;
        end
    endtask
endmodule

// ### sim/adss_seq_props.sv
`timescale 1ns/1ps
// ====================
// Port checker for the sequencer.
module adss_seq_props (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Bus
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire pready_o,
    input wire pslverr_o,
    // Pins
    input wire single_ended_sync_input_i,
    input wire timestamp_diff_input_i,
    input wire link_run_o,
    input wire link_sync_req_o,
    input wire transceiver_ref_out_en_o
);
    reg [7:0] since_rst;
    wire wr_acc = psel_i && penable_i && pwrite_i && pready_o;
    wire wr_ctrl = wr_acc && (paddr_i == 12'h000);
    wire wr_ref = wr_acc && (paddr_i == 12'h010);
    // Saturates so that a long run never wraps back under the init span.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_rst <= 8'h00;
        end else if (since_rst != 8'hff) begin
            since_rst <= since_rst + 8'h01;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_follows: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("pready without setup");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_sync_source: assert property (link_sync_req_o |->
        $past(single_ended_sync_input_i || timestamp_diff_input_i))
        else $error("sync request without a source");
    a_link_after_init: assert property (link_run_o |-> since_rst >= 8'd199)
        else $error("link running before init done");
    a_link_halt: assert property ($fell(link_run_o) |->
        $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("link stopped without control write");
    a_refout_write: assert property ($changed(transceiver_ref_out_en_o) |->
        $past(wr_ref) || $past(wr_ref, 2))
        else $error("reference output changed without write");
endmodule
bind adss_seq adss_seq_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .single_ended_sync_input_i(single_ended_sync_input_i),
    .timestamp_diff_input_i(timestamp_diff_input_i), .link_run_o(link_run_o),
    .link_sync_req_o(link_sync_req_o), .transceiver_ref_out_en_o(transceiver_ref_out_en_o));

// ### sim/adss_seq_tb.sv
`timescale 1ns/1ps
`include "adss_consts.vh"
// ====================
// Bench: host register sequence against the sequencer.
module adss_seq_tb;
    reg clock_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg req = 1'b0;
    reg sel = 1'b0;
    reg [31:0] rd;
    reg er;
    integer err_count = 0;
    integer checked = 0;
    integer n;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, se_sync, ts_sync, trig_pin;
    wire cal_status_pin_o, link_run_o, link_sync_req_o, ref_en;
    always #5 clock_i = ~clock_i;
    adss_rx_model u_rx (.clock_i(clock_i), .req_i(req), .sel_i(sel),
        .single_ended_sync_input_o(se_sync), .timestamp_diff_input_o(ts_sync),
        .cal_trigger_pin_o(trig_pin));
    // Straps are fixed from time zero, before reset is released.
    // Power-down stays low throughout; this block has no pin for it.
    adss_seq uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pll_enable_strap_i(1'b1), .ref_select_strap_i(1'b0),
        .cal_trigger_pin_i(trig_pin), .single_ended_sync_input_i(se_sync),
        .timestamp_diff_input_i(ts_sync), .cal_status_pin_o(cal_status_pin_o),
        .link_run_o(link_run_o), .link_sync_req_o(link_sync_req_o),
        .transceiver_ref_out_en_o(ref_en));
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clock_i);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock_i);
            penable <= 1'b1;
            @(posedge clock_i);
            while (pready_o !== 1'b1) @(posedge clock_i);
            rd = prdata_o;
            er = pslverr_o;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Every status wait is bounded so a stuck bit fails instead of hanging.
    task poll(input [31:0] m);
        begin
            n = 0;
            rd = 32'h0;
            while ((rd & m) !== m && n < 400) begin
                apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
                n = n + 1;
            end
            chk("status poll", m, rd & m);
        end
    endtask
    task settle;
        repeat (2) @(posedge clock_i);
    endtask
    task print_verdict;
        begin
            $display("Comparisons %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    initial begin
        #400000;
        err_count = err_count + 1;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("init early", 32'h0, rd & 32'h1);
        poll(32'h1);
        chk("strap bits", 32'h0, rd & 32'h180);
        apb(1'b0, `ADSS_ADDR_CTRL, 32'h0);
        chk("ctrl reset", `ADSS_CTRL_RESET, rd);
        apb(1'b0, `ADSS_ADDR_PLL, 32'h0);
        chk("pll reset", `ADSS_PLL_RESET_VAL, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, `ADSS_ADDR_PLL, 32'h4a03);
        apb(1'b1, `ADSS_ADDR_PLL, 32'h4a02);
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("vco busy", 32'h0, rd & 32'h2);
        poll(32'h6);
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h0);
        settle;
        chk("link halt", 32'h0, {31'h0, link_run_o});
        apb(1'b1, `ADSS_ADDR_CAL, 32'h3);
        apb(1'b0, `ADSS_ADDR_CAL, 32'h0);
        chk("cal options", 32'h3, rd);
        apb(1'b1, `ADSS_ADDR_LINK, 32'h0308);
        apb(1'b1, `ADSS_ADDR_REFOUT, 32'h1);
        settle;
        chk("ref out", 32'h1, {31'h0, ref_en});
        req <= 1'b1;
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h06);
        settle;
        chk("link run", 32'h1, {31'h0, link_run_o});
        chk("sync mode8", 32'h0, {31'h0, link_sync_req_o});
        apb(1'b1, `ADSS_ADDR_LINK, 32'h0301);
        settle;
        chk("sync mode1", 32'h1, {31'h0, link_sync_req_o});
        sel <= 1'b1;
        settle;
        settle;
        chk("sync other", 32'h0, {31'h0, link_sync_req_o});
        apb(1'b1, `ADSS_ADDR_LINK, 32'h1_0301);
        settle;
        chk("sync stamp", 32'h1, {31'h0, link_sync_req_o});
        req <= 1'b0;
        u_rx.pulse_trig();
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("pin off", 32'h0, rd & 32'h20);
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h26);
        u_rx.pulse_trig();
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("pin cal", 32'h20, rd & 32'h20);
        poll(32'h8);
        settle;
        chk("stat pin", 32'h1, {31'h0, cal_status_pin_o});
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h66);
        settle;
        chk("stat sel", 32'h0, {31'h0, cal_status_pin_o});
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h06);
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h16);
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("sw cal", 32'h20, rd & 32'h20);
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h10);
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("cal halt", 32'h00, rd & 32'h28);
        apb(1'b1, `ADSS_ADDR_CTRL, 32'h01);
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("soft reset", 32'h0, rd & 32'h1);
        poll(32'h1);
        apb(1'b1, `ADSS_ADDR_PLL, 32'h4a01);
        apb(1'b1, `ADSS_ADDR_PLL, 32'h4a00);
        apb(1'b0, `ADSS_ADDR_STATUS, 32'h0);
        chk("manual trim", 32'h2, rd & 32'h6);
        poll(32'h6);
        print_verdict;
    end
endmodule
